// ===== hdl/motor_pkg.sv
package motor_pkg;

  // Clock and pacing.
  localparam int CLK_HZ        = 25_000_000;
  localparam int TICK_US       = 500;
  localparam int TICK_CYCLES   =
    TICK_US * (CLK_HZ / 1_000_000);
  localparam int SPIN_UP_TICKS = 200;

  // Duty figures in percent of the tick period.
  localparam int DUTY_INIT_PCT = 50;
  localparam int DUTY_MAX_PCT  = 90;
  localparam int DUTY_MIN_PCT  = 28;

  localparam int CNT_W = 16;
  localparam logic [15:0] SPEED_STEP = 16'h0001;

  // Register byte offsets.
  localparam logic [3:0] STATUS_OFS    = 4'h0;
  localparam logic [3:0] FLAGS_OFS     = 4'h4;
  localparam logic [3:0] HIGH_TIME_OFS = 4'h8;
  localparam logic [3:0] INPUTS_OFS    = 4'hc;

  // Status and flag field positions.
  localparam int ST_STATE_LSB = 0;
  localparam int ST_DIR_BIT   = 2;
  localparam int ST_BRAKE_BIT = 3;
  localparam int ST_PWM_BIT   = 4;
  localparam int FL_OC_BIT    = 0;
  localparam int FL_OT_BIT    = 1;

  // Synchronised input indices.
  localparam int IN_START = 0;
  localparam int IN_DEC   = 1;
  localparam int IN_INC   = 2;
  localparam int IN_DIR   = 3;
  localparam int IN_OT_N  = 4;
  localparam int IN_OC    = 5;

  // Idle pin levels: buttons released, no faults.
  localparam logic [5:0] RAW_RESET = 6'h1f;

  typedef enum logic [1:0] {
    STOPPED_STATE,
    SPIN_UP_STATE,
    RUNNING_STATE
  } motor_state_t;

  typedef struct packed {
    logic direction_out;
    logic brake_out;
    logic pwm_out;
  } driver_out_t;

  typedef struct packed {
    logic stop_lamp;
    logic forward_lamp;
    logic reverse_lamp;
  } lamp_t;

endpackage

// ===== hdl/dc_motor_pwm_controller.sv
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
module dc_motor_pwm_controller #(
  parameter int TICK_CYCLES   = motor_pkg::TICK_CYCLES,
  parameter int SPIN_UP_TICKS = motor_pkg::SPIN_UP_TICKS
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic [3:0]             switch_inputs_i,
  input  wire logic                   overtemp_in_n_i,
  input  wire logic                   overcurrent_i,
  output motor_pkg::driver_out_t      driver_o,
  output motor_pkg::lamp_t            lamps_o,
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest
);

  localparam int W = motor_pkg::CNT_W;

  // Cycle counts derived from the tick period.
  localparam logic [W-1:0] TICK_LAST =
    W'(TICK_CYCLES - 1);
  localparam logic [W-1:0] LOAD_INIT =
    W'(TICK_CYCLES * motor_pkg::DUTY_INIT_PCT / 100);
  localparam logic [W-1:0] LOAD_MAX =
    W'(TICK_CYCLES * motor_pkg::DUTY_MAX_PCT / 100);
  localparam logic [W-1:0] LOAD_MIN =
    W'(TICK_CYCLES * motor_pkg::DUTY_MIN_PCT / 100);
  localparam logic [W-1:0] SPIN_LAST =
    W'(SPIN_UP_TICKS - 1);

  // Whole state of the controller.
  typedef struct packed {
    logic [5:0]               sync1;
    logic [5:0]               sync2;
    logic [5:0]               sync3;
    logic [5:0]               filt;
    logic [3:0]               dbc_prev;
    logic [3:0]               pressed;
    logic [W-1:0]             tick_cnt;
    logic [W-1:0]             oneshot;
    logic                     os_run;
    logic [W-1:0]             load;
    logic [W-1:0]             spin_cnt;
    motor_pkg::motor_state_t  state;
    motor_pkg::driver_out_t   drv;
    motor_pkg::lamp_t         lamps;
    logic                     oc_flag;
    logic                     ot_flag;
    logic                     ack;
    logic [31:0]              rdata;
  } ctrl_state_t;

  ctrl_state_t s_reg;
  ctrl_state_t s_next;

  // Clamp a proposed load value into the legal duty window.
  function automatic logic [W-1:0] clamp_load(
    input logic [W:0] v
  );
    if (v > {1'b0, LOAD_MAX})
    begin
      clamp_load = LOAD_MAX;
    end
    else if (v < {1'b0, LOAD_MIN})
    begin
      clamp_load = LOAD_MIN;
    end
    else
    begin
      clamp_load = v[W-1:0];
    end
  endfunction

  // Word decode shared by the read and write paths.
  function automatic logic reg_hit(
    input logic [3:0] addr,
    input logic [3:0] ofs
  );
    reg_hit = (addr[3:2] == ofs[3:2]);
  endfunction

  logic       tick;
  logic [3:0] act;
  logic       start_press;
  logic       fault;
  logic       oc_seen;
  logic       ot_seen;
  logic       bus_req;
  logic       wr_take;
  logic [1:0] flag_clr;
  logic [W-1:0] wr_load;
  logic [31:0]  rd_mux;

  // Bus handshake: one wait cycle per access.
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~s_reg.ack;
  assign avs_readdata    = s_reg.rdata;
  assign wr_take         = avs_write & s_reg.ack;
  assign driver_o        = s_reg.drv;
  assign lamps_o         = s_reg.lamps;

  // Read multiplexer; all four words are mapped, unused bits read as zero.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (reg_hit(avs_address, motor_pkg::STATUS_OFS))
    begin
      rd_mux[motor_pkg::ST_STATE_LSB +: 2] = s_reg.state;
      rd_mux[motor_pkg::ST_DIR_BIT]   = s_reg.drv.direction_out;
      rd_mux[motor_pkg::ST_BRAKE_BIT] = s_reg.drv.brake_out;
      rd_mux[motor_pkg::ST_PWM_BIT]   = s_reg.drv.pwm_out;
    end
    else if (reg_hit(avs_address, motor_pkg::FLAGS_OFS))
    begin
      rd_mux[motor_pkg::FL_OC_BIT] = s_reg.oc_flag;
      rd_mux[motor_pkg::FL_OT_BIT] = s_reg.ot_flag;
    end
    else if (reg_hit(avs_address, motor_pkg::HIGH_TIME_OFS))
    begin
      rd_mux[W-1:0] = s_reg.load;
    end
    else if (reg_hit(avs_address, motor_pkg::INPUTS_OFS))
    begin
      rd_mux[3:0] = s_reg.pressed;
    end
  end

  // Byte-lane merge of a write to the high-time register.
  always_comb
  begin
    wr_load = s_reg.load;
    if (avs_byteenable[0])
    begin
      wr_load[7:0] = avs_writedata[7:0];
    end
    if (avs_byteenable[1])
    begin
      wr_load[15:8] = avs_writedata[15:8];
    end
  end

  // Next-state logic for the whole controller.
  always_comb
  begin
    s_next = s_reg;

    // Free-running divider gives the sample tick.
    tick = (s_reg.tick_cnt == TICK_LAST);
    s_next.tick_cnt = tick ? '0 : s_reg.tick_cnt + SPEED_ONE();

    // Three-stage synchroniser; a level is accepted only once the
    // second and third stages agree, which rejects single glitches.
    s_next.sync1 = {overcurrent_i, overtemp_in_n_i, switch_inputs_i};
    s_next.sync2 = s_reg.sync1;
    s_next.sync3 = s_reg.sync2;
    for (int i = 0; i < 6; i++)
    begin
      if (s_reg.sync2[i] == s_reg.sync3[i])
      begin
        s_next.filt[i] = s_reg.sync3[i];
      end
    end

    // Buttons are active low; the direction switch is high for forward.
    act = {s_reg.filt[motor_pkg::IN_DIR], ~s_reg.filt[2:0]};

    // Debounce: pressed only when active on this and the previous tick.
    start_press = 1'b0;
    if (tick)
    begin
      s_next.dbc_prev = act;
      s_next.pressed  = act & s_reg.dbc_prev;
      // Only a fresh press counts, so a held button cannot restart
      // the motor after a fault.
      start_press = s_next.pressed[motor_pkg::IN_START]
                  & ~s_reg.pressed[motor_pkg::IN_START];
    end

    // Held speed buttons move the load one count per tick.
    if (tick && s_next.pressed[motor_pkg::IN_INC]
        && !s_next.pressed[motor_pkg::IN_DEC])
    begin
      s_next.load = clamp_load({1'b0, s_reg.load} + {1'b0, motor_pkg::SPEED_STEP});
    end
    else if (tick && s_next.pressed[motor_pkg::IN_DEC]
             && !s_next.pressed[motor_pkg::IN_INC])
    begin
      s_next.load = clamp_load({1'b0, s_reg.load} - {1'b0, motor_pkg::SPEED_STEP});
    end

    // Software may also set the load; it passes the same clamp.
    if (wr_take && reg_hit(avs_address, motor_pkg::HIGH_TIME_OFS))
    begin
      s_next.load = clamp_load({1'b0, wr_load});
    end

    // Faults are watched only once spin-up is over.
    oc_seen = s_reg.filt[motor_pkg::IN_OC];
    ot_seen = ~s_reg.filt[motor_pkg::IN_OT_N];
    fault   = (s_reg.state == motor_pkg::RUNNING_STATE)
            & (oc_seen | ot_seen);

    // Sticky event flags, write one to clear; a new event wins.
    flag_clr = 2'b00;
    if (wr_take && reg_hit(avs_address, motor_pkg::FLAGS_OFS))
    begin
      flag_clr = avs_writedata[1:0];
    end
    s_next.oc_flag = (s_reg.oc_flag & ~flag_clr[motor_pkg::FL_OC_BIT])
                   | (fault & oc_seen);
    s_next.ot_flag = (s_reg.ot_flag & ~flag_clr[motor_pkg::FL_OT_BIT])
                   | (fault & ot_seen);

    // High-time one-shot: counts down, stops at zero, drops PWM.
    if (s_reg.os_run)
    begin
      if (s_reg.oneshot == motor_pkg::SPEED_STEP)
      begin
        s_next.oneshot     = '0;
        s_next.os_run      = 1'b0;
        s_next.drv.pwm_out = 1'b0;
      end
      else
      begin
        s_next.oneshot = s_reg.oneshot - motor_pkg::SPEED_STEP;
      end
    end

    // Operating sequence.
    case (s_reg.state)
      motor_pkg::STOPPED_STATE:
      begin
        // Direction may only change with the motor braked.
        if (tick)
        begin
          s_next.drv.direction_out =
            s_next.pressed[motor_pkg::IN_DIR];
        end
        if (start_press)
        begin
          s_next.state    = motor_pkg::SPIN_UP_STATE;
          s_next.spin_cnt = '0;
        end
      end
      motor_pkg::SPIN_UP_STATE:
      begin
        if (start_press)
        begin
          s_next.state = motor_pkg::STOPPED_STATE;
        end
        else if (tick)
        begin
          if (s_reg.spin_cnt == SPIN_LAST)
          begin
            // Protection and the one-shot come alive together.
            s_next.state   = motor_pkg::RUNNING_STATE;
            s_next.oneshot = s_reg.load;
            s_next.os_run  = 1'b1;
          end
          else
          begin
            s_next.spin_cnt = s_reg.spin_cnt + motor_pkg::SPEED_STEP;
          end
        end
      end
      motor_pkg::RUNNING_STATE:
      begin
        if (fault)
        begin
          s_next.state = motor_pkg::STOPPED_STATE;
        end
        else if (start_press)
        begin
          s_next.state = motor_pkg::STOPPED_STATE;
        end
        else if (tick)
        begin
          // Each period raises PWM and re-arms the one-shot with the
          // current load, which is the only speed control there is.
          s_next.drv.pwm_out = 1'b1;
          s_next.oneshot     = s_reg.load;
          s_next.os_run      = 1'b1;
        end
      end
      default:
      begin
        s_next.state = motor_pkg::STOPPED_STATE;
      end
    endcase

    // Outside running the one-shot is idle and PWM is steady:
    // low when stopped, fully on while the motor spins up.
    if (s_next.state != motor_pkg::RUNNING_STATE)
    begin
      s_next.os_run      = 1'b0;
      s_next.oneshot     = '0;
      s_next.drv.pwm_out =
        (s_next.state == motor_pkg::SPIN_UP_STATE);
    end

    // Brake follows the state on the same edge, so a fault brakes
    // in the cycle after it is filtered.
    s_next.drv.brake_out =
      (s_next.state == motor_pkg::STOPPED_STATE);

    // Lamps follow the next state.
    s_next.lamps.stop_lamp =
      (s_next.state == motor_pkg::STOPPED_STATE);
    s_next.lamps.forward_lamp = !s_next.lamps.stop_lamp
                              && s_next.drv.direction_out;
    s_next.lamps.reverse_lamp = !s_next.lamps.stop_lamp
                              && !s_next.drv.direction_out;

    // Bus answer: capture read data while waitrequest is high.
    s_next.ack = bus_req & ~s_reg.ack;
    if (avs_read && !s_reg.ack)
    begin
      s_next.rdata = rd_mux;
    end
  end

  // Unit increment, kept as a function so width stays exact.
  function automatic logic [W-1:0] SPEED_ONE();
    SPEED_ONE = motor_pkg::SPEED_STEP;
  endfunction

  // State register; reset puts the motor braked with the stop lamp on,
  // only the tick divider running.
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_reg.sync1    <= motor_pkg::RAW_RESET;
      s_reg.sync2    <= motor_pkg::RAW_RESET;
      s_reg.sync3    <= motor_pkg::RAW_RESET;
      s_reg.filt     <= motor_pkg::RAW_RESET;
      s_reg.dbc_prev <= 4'h0;
      s_reg.pressed  <= 4'h0;
      s_reg.tick_cnt <= '0;
      s_reg.oneshot  <= '0;
      s_reg.os_run   <= 1'b0;
      s_reg.load     <= LOAD_INIT;
      s_reg.spin_cnt <= '0;
      s_reg.state    <= motor_pkg::STOPPED_STATE;
      s_reg.drv.direction_out <= 1'b0;
      s_reg.drv.brake_out     <= 1'b1;
      s_reg.drv.pwm_out       <= 1'b0;
      s_reg.lamps.stop_lamp    <= 1'b1;
      s_reg.lamps.forward_lamp <= 1'b0;
      s_reg.lamps.reverse_lamp <= 1'b0;
      s_reg.oc_flag  <= 1'b0;
      s_reg.ot_flag  <= 1'b0;
      s_reg.ack      <= 1'b0;
      s_reg.rdata    <= 32'h0000_0000;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule // dc_motor_pwm_controller

// ===== tb/motor_props.sv
module motor_props #(
  parameter int TICK_CYCLES   = 100,
  parameter int SPIN_UP_TICKS = 3
) (
  input wire logic                   core_clk_i,
  input wire logic                   rst_b_i,
  input wire logic                   overtemp_in_n_i,
  input wire logic                   overcurrent_i,
  input wire motor_pkg::driver_out_t driver_o,
  input wire motor_pkg::lamp_t       lamps_o,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  int   run_cnt;
  logic run_ok;

  // Cycles since the brake let go; faults only count once spin-up is surely over.
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      run_cnt <= 0;
    else if (driver_o.brake_out)
      run_cnt <= 0;
    else if (run_cnt < 1_000_000)
      run_cnt <= run_cnt + 1;

  assign run_ok = run_cnt > (SPIN_UP_TICKS + 1) * TICK_CYCLES;

  property p_brake_lamp;
    driver_o.brake_out == lamps_o.stop_lamp;
  endproperty
  property p_dir_lamp;
    !lamps_o.stop_lamp |-> lamps_o.forward_lamp == driver_o.direction_out &&
      lamps_o.reverse_lamp != driver_o.direction_out;
  endproperty
  property p_dir_hold;
    !lamps_o.stop_lamp && !$past(lamps_o.stop_lamp) |-> $stable(driver_o.direction_out);
  endproperty
  property p_pwm_brake;
    driver_o.brake_out |-> !driver_o.pwm_out;
  endproperty
  property p_spin_hold;
    $fell(driver_o.brake_out) |-> (!driver_o.brake_out && driver_o.pwm_out) [*8];
  endproperty
  property p_oc_stop;
    (overcurrent_i && run_ok) [*5] |-> ##[0:4] driver_o.brake_out;
  endproperty
  property p_ot_stop;
    (!overtemp_in_n_i && run_ok) [*5] |-> ##[0:4] driver_o.brake_out;
  endproperty
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_rdata_hold;
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
  endproperty

  a_brake_lamp: assert property (p_brake_lamp) else $error("brake and stop lamp differ");
  a_dir_lamp: assert property (p_dir_lamp) else $error("direction lamp wrong");
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved while on");
  a_pwm_brake: assert property (p_pwm_brake) else $error("pwm high while braked");
  a_spin_hold: assert property (p_spin_hold) else $error("spin-up not held");
  a_oc_stop: assert property (p_oc_stop) else $error("overcurrent did not brake");
  a_ot_stop: assert property (p_ot_stop) else $error("overtemp did not brake");
  a_wait_one: assert property (p_wait_one) else $error("wait state not one cycle");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  c_start: cover property ($fell(driver_o.brake_out));
  c_fault: cover property (run_ok && $rose(driver_o.brake_out));
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule // motor_props

bind dc_motor_pwm_controller motor_props #(
  .TICK_CYCLES  (TICK_CYCLES),
  .SPIN_UP_TICKS(SPIN_UP_TICKS)
) u_motor_props (
  .core_clk_i     (core_clk_i),
  .rst_b_i        (rst_b_i),
  .overtemp_in_n_i(overtemp_in_n_i),
  .overcurrent_i  (overcurrent_i),
  .driver_o       (driver_o),
  .lamps_o        (lamps_o),
  .avs_read       (avs_read),
  .avs_write      (avs_write),
  .avs_readdata   (avs_readdata),
  .avs_waitrequest(avs_waitrequest)
);

// ===== tb/motor_driver_model.sv
module motor_driver_model (
  input wire motor_pkg::driver_out_t driver_i,
  input wire logic                   load_i,
  input wire logic                   heat_i,
  output logic                       overcurrent_o,
  output logic                       overtemp_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Braking shorts the windings, so sense current only flows with the brake off.
  assign overcurrent_o = load_i && !driver_i.brake_out;
  // Open-drain flag with pull-up: pulled low while hot, high when released.
  assign overtemp_n_o = heat_i ? 1'b0 : 1'b1;
endmodule // motor_driver_model

// ===== tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 100;
  localparam int SPIN = 3;
  localparam int HT0  = TICK * motor_pkg::DUTY_INIT_PCT / 100;
  localparam int HTX  = TICK * motor_pkg::DUTY_MAX_PCT / 100;
  localparam int HTN  = TICK * motor_pkg::DUTY_MIN_PCT / 100;

  logic                   core_clk_i;
  logic                   rst_b_i;
  logic [3:0]             sw;
  logic                   load;
  logic                   heat;
  logic                   oc;
  logic                   ot_n;
  motor_pkg::driver_out_t drv;
  motor_pkg::lamp_t       lmp;
  logic [3:0]             addr;
  logic                   rd;
  logic                   wr;
  logic [31:0]            wdata;
  logic [31:0]            rdata;
  logic                   waitreq;
  logic [31:0]            q;
  logic [31:0]            a;
  int                     n;
  int                     m;
  int                     error_cnt;
  int                     samples_checked;

  dc_motor_pwm_controller #(.TICK_CYCLES(TICK), .SPIN_UP_TICKS(SPIN)) u_dc_motor_pwm_controller (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .switch_inputs_i(sw),
    .overtemp_in_n_i(ot_n), .overcurrent_i(oc), .driver_o(drv), .lamps_o(lmp),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(waitreq));

  motor_driver_model u_motor_driver_model (
    .driver_i(drv), .load_i(load), .heat_i(heat), .overcurrent_o(oc), .overtemp_n_o(ot_n));

  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  // One Avalon access: held until waitrequest is sampled low, data taken at that edge.
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] v,
                     output logic [31:0] r);
    int i;
    @(posedge core_clk_i);
    rd <= !w;
    wr <= w;
    addr <= ad;
    wdata <= v;
    for (i = 0; i < 20; i++)
    begin
      @(posedge core_clk_i);
      if (waitreq === 1'b0)
        break;
    end
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (i == 20)
    begin
      chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
      summarize();
    end
  endtask

  task automatic rchk(input string nm, input logic [3:0] ad, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, ad, 32'h0000_0000, r);
    chk(nm, e, r);
  endtask

  task automatic ticks(input int k);
    repeat (k * TICK) @(posedge core_clk_i);
  endtask

  // Counts edges until a driver line reads the given level; bounded.
  task automatic wait_bit(input int b, input logic lvl, output int c);
    for (c = 1; c < 2000; c++)
    begin
      @(posedge core_clk_i);
      if (drv[b] === lvl)
        break;
    end
    if (c == 2000)
    begin
      chk("driver_wait", 32'h0000_0000, 32'h0000_0001);
      summarize();
    end
  endtask

  function automatic logic [31:0] st(input logic [1:0] s, input logic d, b, p);
    st = 32'h0000_0000;
    st[1:0] = s;
    st[motor_pkg::ST_DIR_BIT] = d;
    st[motor_pkg::ST_BRAKE_BIT] = b;
    st[motor_pkg::ST_PWM_BIT] = p;
  endfunction

  initial
  begin
    repeat (90000) @(posedge core_clk_i);
    chk("watchdog", 32'h0000_0000, 32'h0000_0001);
    summarize();
  end

  // Buttons are active low; the selector starts at reverse.
  initial
  begin
    rst_b_i = 1'b0;
    sw = 4'h7;
    load = 1'b0;
    heat = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    error_cnt = 0;
    samples_checked = 0;
    repeat (6) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    chk("lamps", 32'h0000_0004, 32'(lmp));
    chk("driver", 32'h0000_0002, 32'(drv));
    rchk("status", motor_pkg::STATUS_OFS, st(2'd0, 1'b0, 1'b1, 1'b0));
    rchk("high_time", motor_pkg::HIGH_TIME_OFS, 32'(HT0));
    $display("test reset done");
    bus(1'b1, motor_pkg::HIGH_TIME_OFS, 32'h0000_ffff, q);
    rchk("ht_max", motor_pkg::HIGH_TIME_OFS, 32'(HTX));
    bus(1'b1, motor_pkg::HIGH_TIME_OFS, 32'h0000_0000, q);
    rchk("ht_min", motor_pkg::HIGH_TIME_OFS, 32'(HTN));
    bus(1'b1, motor_pkg::HIGH_TIME_OFS, 32'h0000_003c, q);
    rchk("ht_set", motor_pkg::HIGH_TIME_OFS, 32'h0000_003c);
    bus(1'b1, motor_pkg::STATUS_OFS, 32'hffff_ffff, q);
    rchk("status_ro", motor_pkg::STATUS_OFS, st(2'd0, 1'b0, 1'b1, 1'b0));
    sw[3] <= 1'b1;
    ticks(4);
    chk("dir", 32'h0000_0001, 32'(drv.direction_out));
    rchk("inputs", motor_pkg::INPUTS_OFS, 32'h0000_0008);
    $display("test registers done");
    sw[0] <= 1'b0;
    wait_bit(1, 1'b0, n);
    sw[0] <= 1'b1;
    sw[3] <= 1'b0;
    load <= 1'b1;
    rchk("spin_up", motor_pkg::STATUS_OFS, st(2'd1, 1'b1, 1'b0, 1'b1));
    chk("run_lamps", 32'h0000_0002, 32'(lmp));
    load <= 1'b0;
    ticks(SPIN + 2);
    bus(1'b0, motor_pkg::STATUS_OFS, 32'h0000_0000, q);
    chk("running", st(2'd2, 1'b1, 1'b0, 1'b0), q & 32'h0000_000f);
    sw[3] <= 1'b1;
    // Start from a low phase, so that a pulse already under way is not measured.
    wait_bit(0, 1'b0, n);
    wait_bit(0, 1'b1, n);
    wait_bit(0, 1'b0, n);
    chk("pwm_high", 32'h0000_003c, 32'(n));
    wait_bit(0, 1'b1, m);
    chk("pwm_period", 32'(TICK), 32'(n + m));
    $display("test run done");
    sw[2] <= 1'b0;
    ticks(40);
    rchk("inc_clamp", motor_pkg::HIGH_TIME_OFS, 32'(HTX));
    sw[2] <= 1'b1;
    sw[1] <= 1'b0;
    ticks(4);
    bus(1'b0, motor_pkg::HIGH_TIME_OFS, 32'h0000_0000, a);
    // The two captures then lie exactly ten tick periods apart, whatever the phase.
    repeat (10 * TICK - 3) @(posedge core_clk_i);
    bus(1'b0, motor_pkg::HIGH_TIME_OFS, 32'h0000_0000, q);
    chk("dec_step", 32'h0000_000a, a - q);
    ticks(80);
    rchk("dec_clamp", motor_pkg::HIGH_TIME_OFS, 32'(HTN));
    sw[1] <= 1'b1;
    $display("test speed done");
    load <= 1'b1;
    wait_bit(1, 1'b1, n);
    load <= 1'b0;
    chk("oc_fast", 32'h0000_0001, 32'(n <= 6));
    rchk("oc_flag", motor_pkg::FLAGS_OFS, 32'h0000_0001);
    bus(1'b1, motor_pkg::FLAGS_OFS, 32'h0000_0001, q);
    rchk("flag_clr", motor_pkg::FLAGS_OFS, 32'h0000_0000);
    ticks(5);
    chk("no_restart", 32'h0000_0001, 32'(drv.brake_out));
    sw[0] <= 1'b0;
    wait_bit(1, 1'b0, n);
    sw[0] <= 1'b1;
    ticks(SPIN + 2);
    heat <= 1'b1;
    wait_bit(1, 1'b1, n);
    heat <= 1'b0;
    chk("ot_fast", 32'h0000_0001, 32'(n <= 6));
    rchk("ot_flag", motor_pkg::FLAGS_OFS, 32'h0000_0002);
    $display("test faults done");
    sw[0] <= 1'b0;
    wait_bit(1, 1'b0, n);
    sw[0] <= 1'b1;
    ticks(SPIN + 2);
    sw[0] <= 1'b0;
    wait_bit(1, 1'b1, n);
    sw[0] <= 1'b1;
    rchk("stop_press", motor_pkg::STATUS_OFS, st(2'd0, 1'b1, 1'b1, 1'b0));
    // Reverse is picked up while stopped and then shown by its own lamp.
    sw[3] <= 1'b0;
    ticks(3);
    sw[0] <= 1'b0;
    wait_bit(1, 1'b0, n);
    sw[0] <= 1'b1;
    chk("rev_lamps", 32'h0000_0001, 32'(lmp));
    $display("test toggle done");
    summarize();
  end
endmodule // tb
